// File: shared/poepr_defines.vh
// Register map, field layout and reset values of the port policy register bank
// Notes on behaviour
// - Class 5 bit enables 40W class per port
// - Class 5 bits load from class5 strap
// - Two-event and power limit load from autonomous strap
// - Two-event classification after first result Class 4/5
// - Priority 11 sheds first, 00 last
// - Equal codes: higher port number sheds first
// - Pin clear releases irq pins, self-clears
// - Source clear wipes sources and pins, self-clears
// - Irq enable gates pins only, events still recorded
// - Power limit enable arms overload shutdown
// - Converter enable switches monitoring converter
// - Watchdog enable, reset zero
`ifndef POEPR_DEFINES_VH
`define POEPR_DEFINES_VH
`define POEPR_ADDR_CLASS       8'h0c
`define POEPR_ADDR_PRIO        8'h0d
`define POEPR_ADDR_IRQ         8'h0e
`define POEPR_ADDR_GEN         8'h0f
`define POEPR_PRIO_RESET       8'he4
`define POEPR_IRQ_PIN_CLR      2
`define POEPR_IRQ_SRC_CLR      1
`define POEPR_IRQ_EN           0
`define POEPR_GEN_PLIM         2
`define POEPR_GEN_CONV         1
`define POEPR_GEN_WDOG         0
`define POEPR_CONV_RESET       1'b1
`define POEPR_WDOG_RESET       1'b0
`define POEPR_IRQ_EN_RESET     1'b1
`define POEPR_CLASS_HI         4'hf
`define POEPR_CLASS_LO         4'h0
`define POEPR_CLS4             3'h4
`define POEPR_CLASS5_STRAP_PIN             3'h5
`define POEPR_PORTS            4
`define POEPR_C5_MSB           7
`define POEPR_C5_LSB           4
`define POEPR_TE_MSB           3
`define POEPR_TE_LSB           0
`define POEPR_PRIO_W           2
`define POEPR_CLS_W            3
`define POEPR_RSVD_ZERO        5'h00
`endif

// File: src/poepr_regs.v
// Port policy register bank with overload shed order and interrupt pin control
`timescale 1ns/1ns
`include "poepr_defines.vh"
module poepr_regs (
  input  wire       clk,                  // 125 MHz clock
  input  wire       rst_n,                // Async reset, active low
  input  wire       class5_strap_pin,     // Strap level for class 5 defaults
  input  wire       autonomous_mode_pin,  // Strap level for autonomous defaults
  input  wire       reg_wr,               // Register write strobe
  input  wire       reg_rd,               // Register read strobe
  input  wire [7:0] reg_addr,             // Register address
  input  wire [7:0] reg_wdata,            // Write data
  input  wire [3:0] event_in,             // Per-port event pulses
  input  wire [3:0] class_done,           // First classification done pulse
  input  wire [11:0] class_result,        // First class result, 3 bits per port
  input  wire       power_at_limit,       // Total power reached limit pin setting
  output reg  [7:0] reg_rdata,            // Read data
  output reg  [3:0] class5_active,        // Class 5 classification enabled
  output reg  [3:0] two_event_go,         // Pulse: do two-event classification
  output reg  [3:0] event_source,         // Interrupt source bits
  output reg        irq_pin_one,          // Interrupt pin one, active high
  output reg        irq_pin_two,          // Interrupt pin two, active high
  output reg        overload_shed,        // Pulse: shed one port
  output reg  [1:0] shed_port,            // Port index being shed
  output reg        converter_on,         // Monitoring converter on
  output reg        watchdog_on           // Bus watchdog on
);
  // Configuration registers
  reg       strap_pending;
  reg [3:0] class5_enable;
  reg [3:0] two_event_enable;
  reg [7:0] shutdown_priority;
  reg       interrupt_pin_clear;
  reg       interrupt_source_clear;
  reg       irq_output_enable;
  reg       total_power_limit_enable;
  reg       converter_enable;
  reg       bus_watchdog_enable;

  // Interrupt, shed and next-value state
  reg       irq_latched;
  reg [3:0] shed_done;
  reg       next_valid;
  reg [1:0] next_idx;
  reg [3:0] next_two_event;
  reg [7:0] next_rdata;
  integer   i;
  integer   j;

  // Shed rank: code in high bits, port index breaks ties toward higher ports
  function [3:0] rank;
    input [1:0] code;
    input [1:0] port;
    begin
      rank = {code, port};
    end
  endfunction

  // Two-bit priority code of one port
  function [1:0] prio_of;
    input [7:0] prio;
    input [1:0] port;
    begin
      prio_of = prio[`POEPR_PRIO_W*port +: `POEPR_PRIO_W];
    end
  endfunction

  // Class 4 or Class 5 first result asks for a second event
  function high_class;
    input [2:0] result;
    begin
      high_class = (result == `POEPR_CLS4) || (result == `POEPR_CLASS5_STRAP_PIN);
    end
  endfunction

  // Next port to shed: highest rank among ports not yet shed
  always @* begin
    next_valid = 1'b0;
    next_idx   = 2'h0;
    for (i = 0; i < `POEPR_PORTS; i = i + 1) begin
      if (!shed_done[i] && (!next_valid ||
          rank(prio_of(shutdown_priority, i[1:0]), i[1:0]) >=
          rank(prio_of(shutdown_priority, next_idx), next_idx))) begin
        next_idx   = i[1:0];
        next_valid = 1'b1;
      end
    end
  end

  // Second event only on an enabled port with a Class 4 or 5 result
  always @* begin
    next_two_event = 4'h0;
    for (j = 0; j < `POEPR_PORTS; j = j + 1)
      next_two_event[j] = class_done[j] & two_event_enable[j] &
                          high_class(class_result[`POEPR_CLS_W*j +: `POEPR_CLS_W]);
  end

  // Reserved and unmapped bits read as zero
  // Clear bits read 1 for the single cycle they stand
  always @* begin
    case (reg_addr)
      `POEPR_ADDR_CLASS: next_rdata = {class5_enable, two_event_enable};
      `POEPR_ADDR_PRIO:  next_rdata = shutdown_priority;
      `POEPR_ADDR_IRQ:   next_rdata = {`POEPR_RSVD_ZERO, interrupt_pin_clear,
                                       interrupt_source_clear, irq_output_enable};
      `POEPR_ADDR_GEN:   next_rdata = {`POEPR_RSVD_ZERO, total_power_limit_enable,
                                       converter_enable, bus_watchdog_enable};
      default:           next_rdata = 8'h00;
    endcase
  end

  // Straps caught on the first edge after release, never under reset
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      strap_pending            <= 1'b1;
      class5_enable            <= `POEPR_CLASS_LO;
      two_event_enable         <= `POEPR_CLASS_LO;
      total_power_limit_enable <= 1'b0;
      shutdown_priority        <= `POEPR_PRIO_RESET;
      interrupt_pin_clear      <= 1'b0;
      interrupt_source_clear   <= 1'b0;
      irq_output_enable        <= `POEPR_IRQ_EN_RESET;
      converter_enable         <= `POEPR_CONV_RESET;
      bus_watchdog_enable      <= `POEPR_WDOG_RESET;
    end else begin
      // Self-clear first so a fresh clear command is never lost
      if (interrupt_pin_clear)
        interrupt_pin_clear <= 1'b0;
      if (interrupt_source_clear)
        interrupt_source_clear <= 1'b0;
      // A write in the strap cycle is lost; hosts wait one more edge
      if (strap_pending) begin
        strap_pending            <= 1'b0;
        class5_enable            <= class5_strap_pin ? `POEPR_CLASS_HI : `POEPR_CLASS_LO;
        two_event_enable         <= autonomous_mode_pin ? `POEPR_CLASS_HI
                                                        : `POEPR_CLASS_LO;
        total_power_limit_enable <= autonomous_mode_pin;
      end else if (reg_wr) begin
        // Unmapped addresses fall through untouched
        case (reg_addr)
          `POEPR_ADDR_CLASS: begin
            class5_enable    <= reg_wdata[`POEPR_C5_MSB:`POEPR_C5_LSB];
            two_event_enable <= reg_wdata[`POEPR_TE_MSB:`POEPR_TE_LSB];
          end
          `POEPR_ADDR_PRIO: shutdown_priority <= reg_wdata;
          `POEPR_ADDR_IRQ: begin
            interrupt_pin_clear    <= reg_wdata[`POEPR_IRQ_PIN_CLR];
            interrupt_source_clear <= reg_wdata[`POEPR_IRQ_SRC_CLR];
            irq_output_enable      <= reg_wdata[`POEPR_IRQ_EN];
          end
          `POEPR_ADDR_GEN: begin
            total_power_limit_enable <= reg_wdata[`POEPR_GEN_PLIM];
            converter_enable         <= reg_wdata[`POEPR_GEN_CONV];
            bus_watchdog_enable      <= reg_wdata[`POEPR_GEN_WDOG];
          end
          default: ;
        endcase
      end
    end
  end

  // Events always recorded; a new event beats a same-cycle clear
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      event_source <= 4'h0;
      irq_latched  <= 1'b0;
      irq_pin_one  <= 1'b0;
      irq_pin_two  <= 1'b0;
    end else begin
      event_source <= (interrupt_source_clear ? 4'h0 : event_source) | event_in;
      if (interrupt_pin_clear || interrupt_source_clear)
        irq_latched <= |event_in;
      else if (|event_in)
        irq_latched <= 1'b1;
      // Both pins follow one latch; no per-pin source routing here
      irq_pin_one <= irq_latched & irq_output_enable;
      irq_pin_two <= irq_latched & irq_output_enable;
    end
  end

  // Overload: one port shed per cycle until the limit drops or every port is shed
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      shed_done     <= 4'h0;
      overload_shed <= 1'b0;
      shed_port     <= 2'h0;
    end else begin
      overload_shed <= 1'b0;
      // Limit dropping or the enable cleared rearms the whole order
      if (!total_power_limit_enable || !power_at_limit) begin
        shed_done <= 4'h0;
      end else if (next_valid) begin
        overload_shed       <= 1'b1;
        shed_port           <= next_idx;
        shed_done[next_idx] <= 1'b1;
      end
    end
  end

  // Output copies lag their register by one edge; two_event_go lags the class_done pulse by one edge
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      two_event_go  <= 4'h0;
      class5_active <= 4'h0;
      converter_on  <= 1'b0;
      watchdog_on   <= 1'b0;
    end else begin
      two_event_go  <= next_two_event;
      class5_active <= class5_enable;
      converter_on  <= converter_enable;
      watchdog_on   <= bus_watchdog_enable;
    end
  end

  // Read data stands until the next read
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n)
      reg_rdata <= 8'h00;
    else if (reg_rd)
      reg_rdata <= next_rdata;
  end
endmodule

// File: sim/poepr_host.sv
// Host model that reaches the register bank one access at a time
`timescale 1ns/1ns
module poepr_host (
  input  wire       clk,        // Bench clock
  output reg        reg_wr,     // Write strobe
  output reg        reg_rd,     // Read strobe
  output reg  [7:0] reg_addr,   // Address
  output reg  [7:0] reg_wdata,  // Write data
  input  wire [7:0] reg_rdata   // Read data
);
  initial {reg_wr, reg_rd, reg_addr, reg_wdata} = 18'h0;
  // Released data shows the inverse so a stale value cannot pass
  task wr(input [7:0] a, input [7:0] d);
    @(negedge clk) {reg_wr, reg_addr, reg_wdata} = {1'b1, a, d};
    @(negedge clk) {reg_wr, reg_wdata} = {1'b0, ~d};
  endtask
  task rd(input [7:0] a, output [7:0] d);
    @(negedge clk) {reg_rd, reg_addr} = {1'b1, a};
    @(negedge clk) reg_rd = 1'b0;
    d = reg_rdata;
  endtask
endmodule

// File: sim/poepr_regs_sva.sv
// Port-level assertions for the port policy register bank
`timescale 1ns/1ns
module poepr_regs_sva (
  input wire       clk,             // Clock
  input wire       rst_n,           // Async reset, active low
  input wire       reg_wr,          // Write strobe
  input wire       reg_rd,          // Read strobe
  input wire       power_at_limit,  // Total power at limit
  input wire [7:0] reg_addr,        // Register address
  input wire [7:0] reg_wdata,       // Write data
  input wire [7:0] reg_rdata,       // Read data
  input wire [3:0] event_in,        // Per-port events
  input wire [3:0] class5_active,   // Class 5 enables seen
  input wire [3:0] event_source,    // Sticky sources
  input wire       irq_pin_one,     // Interrupt pin one
  input wire       irq_pin_two,     // Interrupt pin two
  input wire       overload_shed,   // Shed pulse
  input wire       converter_on,    // Converter on
  input wire       watchdog_on      // Watchdog on
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  sequence s_wr(a, b); reg_wr && reg_addr == a && b && event_in == 4'h0; endsequence
  sequence s_quiet; event_in == 4'h0 [*4]; endsequence
  property p_conv;
    s_wr(8'h0f, 1) |-> ##2 converter_on == $past(reg_wdata[1], 2);
  endproperty
  property p_wdog;
    s_wr(8'h0f, 1) |-> ##2 watchdog_on == $past(reg_wdata[0], 2);
  endproperty
  property p_class5;
    s_wr(8'h0c, 1) |-> ##2 class5_active == $past(reg_wdata[7:4], 2);
  endproperty
  property p_src;
    s_wr(8'h0e, reg_wdata[1]) ##1 s_quiet |=> event_source == 4'h0;
  endproperty
  property p_pin;
    s_wr(8'h0e, reg_wdata[2]) ##1 s_quiet |=> !irq_pin_one && !irq_pin_two;
  endproperty
  property p_unmap;
    reg_rd && (reg_addr < 8'h0c || reg_addr > 8'h0f) |=> reg_rdata == 8'h00;
  endproperty
  a_conv_copy: assert property (p_conv)
    else $error("converter copy wrong");
  a_wdog_copy: assert property (p_wdog)
    else $error("watchdog copy wrong");
  a_class5_copy: assert property (p_class5)
    else $error("class5 copy wrong");
  a_src_clear: assert property (p_src)
    else $error("sources not cleared");
  a_pin_clear: assert property (p_pin)
    else $error("pins not released");
  a_irq_resv: assert property (reg_rd && reg_addr == 8'h0e |=> reg_rdata[7:3] == 5'h00)
    else $error("reserved bits set");
  a_unmap_zero: assert property (p_unmap)
    else $error("unmapped read not zero");
  a_rdata_hold: assert property (!reg_rd |=> $stable(reg_rdata))
    else $error("read data moved");
  a_shed_idle: assert property (!power_at_limit [*3] |-> !overload_shed)
    else $error("shed without overload");
endmodule
bind poepr_regs poepr_regs_sva u_sva (.clk, .rst_n, .reg_wr, .reg_rd, .power_at_limit, .reg_addr,
  .reg_wdata, .reg_rdata, .event_in, .class5_active, .event_source, .irq_pin_one, .irq_pin_two,
  .overload_shed, .converter_on, .watchdog_on);

// File: sim/poepr_regs_tb.sv
// Self-checking bench for the port policy register bank
`timescale 1ns/1ns
module poepr_regs_tb;
  logic clk, rst_n, s5, au, pal, rd, wr, i1, i2, sh, cv, wg;
  logic [7:0] addr, wd, rdt, v, a, d, pr;
  logic [3:0] ev, cd, c5, tg, es, te, g, ec5;
  logic [11:0] cr;
  logic [1:0] sp, ecw;
  int num_errors = 0, comparisons = 0, k, cl, q[$], got[$];
  poepr_host host (.clk, .reg_wr(wr), .reg_rd(rd), .reg_addr(addr), .reg_wdata(wd),
    .reg_rdata(rdt));
  poepr_regs dut (.clk, .rst_n, .class5_strap_pin(s5), .autonomous_mode_pin(au), .reg_wr(wr),
    .reg_rd(rd), .reg_addr(addr), .reg_wdata(wd), .event_in(ev), .class_done(cd),
    .class_result(cr), .power_at_limit(pal), .reg_rdata(rdt), .class5_active(c5),
    .two_event_go(tg), .event_source(es), .irq_pin_one(i1), .irq_pin_two(i2),
    .overload_shed(sh), .shed_port(sp), .converter_on(cv), .watchdog_on(wg));
  task chk(input logic [7:0] seen, exp);
    comparisons++;
    if (seen !== exp) begin
      num_errors++;
      $display("CHECK FAILED %0t seen %h want %h", $time, seen, exp);
    end
  endtask
  task rchk(input [7:0] ad, e);
    host.rd(ad, v);
    chk(v, e);
  endtask
  task summarize;
    $display("%0d comparisons, %0d mismatches", comparisons, num_errors);
    if (num_errors == 0 && comparisons > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  function automatic [7:0] msk(input [7:0] x);
    msk = x == 8'h0e ? 8'h01 : x == 8'h0f ? 8'h07 : x < 8'h0c || x > 8'h0f ? 8'h00 : 8'hff;
  endfunction
  // Code 11 first, ties go to the higher port
  function automatic void order(input [7:0] p);
    q = {};
    for (int c = 3; c >= 0; c--)
      for (int j = 3; j >= 0; j--)
        if (p[2*j +: 2] == c) q.push_back(j);
  endfunction
  initial begin
    clk = 0;
    forever #4 clk = ~clk;
  end
  initial begin
    #200000;
    num_errors++;
    summarize;
  end
  initial begin
    {rst_n, pal, ev, cd, cr} = '0;
    s5 = 1'($urandom(37));
    au = 1'($urandom);
    repeat (10) @(negedge clk);
    rst_n = 1;
    repeat (2) @(negedge clk);
    rchk(8'h0c, {{4{s5}}, {4{au}}});
    rchk(8'h0d, 8'he4);
    rchk(8'h0e, 8'h01);
    rchk(8'h0f, {5'h0, au, 2'b10});
    {ec5, ecw} = {{4{s5}}, 2'b10};
    $display("defaults done");
    for (int i = 0; i < 24; i++) begin
      a = 8'($urandom_range(8'h0b, 8'h10));
      d = 8'($urandom) & (a == 8'h0e ? 8'hf9 : 8'hff);
      host.wr(a, d);
      if (a == 8'h0c) ec5 = d[7:4];
      if (a == 8'h0f) ecw = d[1:0];
      rchk(a, d & msk(a));
      chk({2'b0, c5, cv, wg}, {2'b0, ec5, ecw});
    end
    $display("register access done");
    te = 4'($urandom);
    host.wr(8'h0c, {4'h0, te});
    for (int i = 0; i < 12; i++) begin
      {k, cl} = {i % 4, 3 + i / 4};
      {cd, cr} = {4'h1 << k, 12'(cl) << (3 * k)};
      @(negedge clk) {g, cd} = {tg, 4'h0};
      @(negedge clk) g = g | tg;
      chk({4'h0, g}, {4'h0, te[k] && cl > 3 ? 4'h1 << k : 4'h0});
    end
    $display("two-event done");
    host.wr(8'h0e, 8'h00);
    @(negedge clk) ev = 4'h5;
    @(negedge clk) ev = 4'h0;
    repeat (3) @(negedge clk);
    chk({es, 2'b0, i1, i2}, 8'h50);
    host.wr(8'h0e, 8'h01);
    @(negedge clk) ev = 4'h2;
    @(negedge clk) ev = 4'h0;
    repeat (3) @(negedge clk);
    chk({es, 2'b0, i1, i2}, 8'h73);
    host.wr(8'h0e, 8'h05);
    repeat (4) @(negedge clk);
    chk({es, 2'b0, i1, i2}, 8'h70);
    host.wr(8'h0e, 8'h03);
    repeat (4) @(negedge clk);
    chk({es, 2'b0, i1, i2}, 8'h00);
    rchk(8'h0e, 8'h01);
    $display("interrupt done");
    // Second reset with both straps turned over
    {rst_n, s5, au} = {1'b0, ~s5, ~au};
    repeat (3) @(negedge clk);
    rst_n = 1;
    repeat (2) @(negedge clk);
    rchk(8'h0c, {{4{s5}}, {4{au}}});
    rchk(8'h0d, 8'he4);
    rchk(8'h0e, 8'h01);
    rchk(8'h0f, {5'h0, au, 2'b10});
    chk({es, 2'b0, i1, i2}, 8'h00);
    $display("second reset done");
    for (int t = 0; t < 4; t++) begin
      pr = t == 0 ? 8'h00 : t == 1 ? 8'hff : 8'($urandom);
      host.wr(8'h0d, pr);
      host.wr(8'h0f, {5'h0, t != 3, 2'b10});
      order(pr);
      if (t == 3) q = {};
      pal = 1'b1;
      got = {};
      repeat (12) @(negedge clk) if (sh === 1'b1) got.push_back(sp);
      pal = 0;
      chk(8'(got.size()), 8'(q.size()));
      foreach (q[j]) chk(8'(got[j]), 8'(q[j]));
      repeat (3) @(negedge clk);
    end
    $display("overload done");
    summarize;
  end
endmodule
